// [dmsc_pkg.sv]
// Package: register map, field positions and types of the converter mode and status block
package dmsc_pkg;

   // Register addresses on the special-function-register bus
   localparam logic [7:0] DMSC_MODE_ADDR = 8'hD1;
   localparam logic [7:0] DMSC_STAT_ADDR = 8'hD8;

   // Reset values
   localparam logic [7:0] DMSC_MODE_RESET = 8'h00;
   localparam logic [7:0] DMSC_STAT_RESET = 8'h00;
   localparam logic [7:0] DMSC_RD_IDLE    = 8'h00;

   // Status register bit positions
   localparam int STAT_PRI_RDY_BIT = 7;
   localparam int STAT_AUX_RDY_BIT = 6;
   localparam int STAT_CAL_BIT     = 5;
   localparam int STAT_NOREF_BIT   = 4;
   localparam int STAT_PRI_ERR_BIT = 3;
   localparam int STAT_AUX_ERR_BIT = 2;

   // Mode register bit positions
   localparam int MODE_PRI_EN_BIT = 5;
   localparam int MODE_AUX_EN_BIT = 4;
   localparam int MODE_OP_MSB     = 2;
   localparam int MODE_OP_LSB     = 0;

   // Result widths of the two converters
   localparam int DMSC_PRI_W = 24;
   localparam int DMSC_AUX_W = 16;

   // Operation field encodings
   typedef enum logic [2:0] {
      OP_POWER_DOWN = 3'b000,
      OP_IDLE       = 3'b001,
      OP_SINGLE     = 3'b010,
      OP_CONTINUOUS = 3'b011,
      OP_CAL_INT_ZS = 3'b100,
      OP_CAL_INT_FS = 3'b101,
      OP_CAL_SYS_ZS = 3'b110,
      OP_CAL_SYS_FS = 3'b111
   } dmsc_op_t;

   // Completion event from one converter's filter
   typedef struct packed {
      logic done;                          // One-cycle completion pulse
      logic saturated;                     // Result hit all zeros or all ones
      logic calFault;                      // Calibration could not produce coefficients
   } dmsc_evt_t;

   // Register bus request
   typedef struct packed {
      logic       write;                   // Write strobe
      logic       read;                    // Read strobe
      logic [7:0] addr;                    // Register address
      logic [7:0] wrData;                  // Write data
   } dmsc_sfr_req_t;

   // Whole state of the block
   typedef struct packed {
      logic                  primaryEnable;
      logic                  auxiliaryEnable;
      dmsc_op_t              operationField;
      logic                  primaryReadyFlag;
      logic                  auxiliaryReadyFlag;
      logic                  calDoneFlag;
      logic                  extReferenceMissing;
      logic                  primaryErrorFlag;
      logic                  auxiliaryErrorFlag;
      logic                  converterReset;
      logic                  primaryResultWrite;
      logic                  auxiliaryResultWrite;
      logic                  primaryCoefWrite;
      logic                  auxiliaryCoefWrite;
      logic [DMSC_PRI_W-1:0] primaryResult;
      logic [DMSC_AUX_W-1:0] auxiliaryResult;
      logic [7:0]            rdData;
   } dmsc_state_t;

endpackage

// [dmsc_ctrl.sv]
// Mode and status register logic for a primary and an auxiliary sigma-delta converter
module dmsc_ctrl #(
   parameter int PRI_WIDTH = 24,                            // Primary result width
   parameter int AUX_WIDTH = 16                             // Auxiliary result width
) (
   input  wire logic                              clock,              // Core clock
   input  wire logic                              rst_n,              // Synchronous reset, active low
   input  wire dmsc_pkg::dmsc_sfr_req_t           sfrReq,             // Register bus request
   output logic [7:0]                             sfrRdData,          // Read data, one cycle after read
   input  wire dmsc_pkg::dmsc_evt_t               primaryEvt,         // Primary completion event
   input  wire logic [dmsc_pkg::DMSC_PRI_W-1:0]   primaryRaw,         // Primary filter output
   input  wire dmsc_pkg::dmsc_evt_t               auxiliaryEvt,       // Auxiliary completion event
   input  wire logic [dmsc_pkg::DMSC_AUX_W-1:0]   auxiliaryRaw,       // Auxiliary filter output
   input  wire logic                              referenceLow,       // Reference detector: pins floating or low
   input  wire logic                              primaryExtRef,      // Primary uses external reference
   input  wire logic                              auxiliaryExtRef,    // Auxiliary uses external reference
   input  wire logic                              tempSensorSelected, // Auxiliary input is temperature sensor
   output dmsc_pkg::dmsc_op_t                     operationField,     // Current operation
   output logic                                   primaryRun,         // Primary enabled and not powered down
   output logic                                   auxiliaryRun,       // Auxiliary enabled and not powered down
   output logic                                   converterReset,     // One-cycle reset of both converters
   output logic                                   primaryResultWrite, // Primary data register load pulse
   output logic [dmsc_pkg::DMSC_PRI_W-1:0]        primaryResult,      // Primary data to load
   output logic                                   primaryCoefWrite,   // Primary coefficient load pulse
   output logic                                   auxiliaryResultWrite, // Auxiliary data register load pulse
   output logic [dmsc_pkg::DMSC_AUX_W-1:0]        auxiliaryResult,    // Auxiliary data to load
   output logic                                   auxiliaryCoefWrite  // Auxiliary coefficient load pulse
);
   import dmsc_pkg::*;

   // Widths are fixed by the package struct; other values cannot be served
   if (PRI_WIDTH != DMSC_PRI_W || AUX_WIDTH != DMSC_AUX_W) begin : g_width_check
      $error("dmsc_ctrl: result widths must match the package");
   end

   dmsc_state_t s;
   dmsc_state_t next_s;

   logic     modeWrite;
   logic     statWrite;
   logic     startOp;
   logic     calOp;
   logic     anyActive;
   logic     primaryAccept;
   logic     auxiliaryAccept;
   dmsc_op_t writtenOp;
   logic [7:0] modeImage;
   logic [7:0] statImage;

   // Decode of bus strobes and of the operation being written
   assign modeWrite = sfrReq.write && (sfrReq.addr == DMSC_MODE_ADDR);
   assign statWrite = sfrReq.write && (sfrReq.addr == DMSC_STAT_ADDR);
   assign writtenOp = dmsc_op_t'(sfrReq.wrData[MODE_OP_MSB:MODE_OP_LSB]);
   assign startOp   = modeWrite && (writtenOp >= OP_SINGLE);
   assign calOp     = (s.operationField >= OP_CAL_INT_ZS);
   assign anyActive = primaryRun || auxiliaryRun;

   // A converter that is enabled but in power-down or idle never completes,
   // so the ready gate is the only acceptance condition needed here
   // result gate
   assign primaryAccept   = primaryEvt.done && !s.primaryReadyFlag;
   assign auxiliaryAccept = auxiliaryEvt.done && !s.auxiliaryReadyFlag;

   // Register images; reserved positions stay zero
   // reserved bits
   always_comb begin
      modeImage = 8'h00;
      modeImage[MODE_PRI_EN_BIT] = s.primaryEnable;
      modeImage[MODE_AUX_EN_BIT] = s.auxiliaryEnable;
      modeImage[MODE_OP_MSB:MODE_OP_LSB] = s.operationField;
      statImage = 8'h00;
      statImage[STAT_PRI_RDY_BIT] = s.primaryReadyFlag;
      statImage[STAT_AUX_RDY_BIT] = s.auxiliaryReadyFlag;
      statImage[STAT_CAL_BIT]     = s.calDoneFlag;
      statImage[STAT_NOREF_BIT]   = s.extReferenceMissing;
      statImage[STAT_PRI_ERR_BIT] = s.primaryErrorFlag;
      statImage[STAT_AUX_ERR_BIT] = s.auxiliaryErrorFlag;
   end

   // Next state: clears first, hardware sets after them so a same-cycle event wins over a clear; a mode write comes last
   always_comb begin
      next_s = s;
      next_s.converterReset       = 1'b0;
      next_s.primaryResultWrite   = 1'b0;
      next_s.auxiliaryResultWrite = 1'b0;
      next_s.primaryCoefWrite     = 1'b0;
      next_s.auxiliaryCoefWrite   = 1'b0;

      // Registered, so the flag lags the detector by one cycle
      // reference detect
      next_s.extReferenceMissing = referenceLow && anyActive;

      // Ones written to the ready bits are ignored, so a read-modify-write is harmless
      // software clear, only zeros take effect
      if (statWrite) begin
         next_s.primaryReadyFlag   = s.primaryReadyFlag & sfrReq.wrData[STAT_PRI_RDY_BIT];
         next_s.auxiliaryReadyFlag = s.auxiliaryReadyFlag & sfrReq.wrData[STAT_AUX_RDY_BIT];
      end

      // starting write clears errors, calibration flag and ready flags
      if (startOp) begin
         next_s.primaryErrorFlag   = 1'b0;
         next_s.auxiliaryErrorFlag = 1'b0;
         next_s.calDoneFlag        = 1'b0;
         next_s.primaryReadyFlag   = 1'b0;
         next_s.auxiliaryReadyFlag = 1'b0;
      end

      if (primaryAccept) begin
         next_s.primaryReadyFlag = 1'b1;
         if (calOp) begin
            next_s.calDoneFlag = 1'b1;
            if (primaryEvt.calFault) begin
               next_s.primaryErrorFlag = 1'b1;
            end else begin
               next_s.primaryCoefWrite = 1'b1;
            end
         end else begin
            next_s.primaryResultWrite = 1'b1;
            if (s.extReferenceMissing && primaryExtRef) begin
               next_s.primaryResult = '1;
            end else begin
               next_s.primaryResult = primaryRaw;
            end
            if (primaryEvt.saturated) begin
               next_s.primaryErrorFlag = 1'b1;
            end
         end
      end

      if (auxiliaryAccept) begin
         next_s.auxiliaryReadyFlag = 1'b1;
         if (calOp) begin
            next_s.calDoneFlag = 1'b1;
            if (auxiliaryEvt.calFault || tempSensorSelected) begin
               next_s.auxiliaryErrorFlag = 1'b1;
            end else begin
               next_s.auxiliaryCoefWrite = 1'b1;
            end
         end else begin
            next_s.auxiliaryResultWrite = 1'b1;
            if (s.extReferenceMissing && auxiliaryExtRef) begin
               next_s.auxiliaryResult = '1;
            end else begin
               next_s.auxiliaryResult = auxiliaryRaw;
            end
            if (auxiliaryEvt.saturated) begin
               next_s.auxiliaryErrorFlag = 1'b1;
            end
         end
      end

      // With both converters enabled the first one to finish ends the one-shot
      // one-shot operations fall back to power-down
      if ((primaryAccept || auxiliaryAccept) && (s.operationField == OP_SINGLE || calOp)) begin
         next_s.operationField = OP_POWER_DOWN;
      end

      // A write that repeats the current value still restarts both converters
      // any mode write resets both converters; it overrides the fall-back
      if (modeWrite) begin
         next_s.primaryEnable   = sfrReq.wrData[MODE_PRI_EN_BIT];
         next_s.auxiliaryEnable = sfrReq.wrData[MODE_AUX_EN_BIT];
         next_s.operationField  = writtenOp;
         next_s.converterReset  = 1'b1;
      end

      // reads of unmapped addresses give zero
      if (sfrReq.read) begin
         case (sfrReq.addr)
            DMSC_MODE_ADDR: begin
               next_s.rdData = modeImage;
            end
            DMSC_STAT_ADDR: begin
               next_s.rdData = statImage;
            end
            default: begin
               next_s.rdData = DMSC_RD_IDLE;
            end
         endcase
      end
   end

   // State register
   // Synchronous reset; every flag and the field start at zero
   // power-down after reset
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state
   assign sfrRdData            = s.rdData;
   assign operationField       = s.operationField;
   assign primaryRun           = s.primaryEnable && (s.operationField != OP_POWER_DOWN);
   assign auxiliaryRun         = s.auxiliaryEnable && (s.operationField != OP_POWER_DOWN);
   assign converterReset       = s.converterReset;
   assign primaryResultWrite   = s.primaryResultWrite;
   assign primaryResult        = s.primaryResult;
   assign primaryCoefWrite     = s.primaryCoefWrite;
   assign auxiliaryResultWrite = s.auxiliaryResultWrite;
   assign auxiliaryResult      = s.auxiliaryResult;
   assign auxiliaryCoefWrite   = s.auxiliaryCoefWrite;

   // Checks of the register behaviour
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_pri_ready_set: assert property (primaryEvt.done && !s.primaryReadyFlag |=> s.primaryReadyFlag)
      else $error("primary ready not set after completion");
   a_pri_block: assert property (s.primaryReadyFlag |=> !primaryResultWrite && !primaryCoefWrite)
      else $error("primary register written while ready set");
   a_aux_block: assert property (s.auxiliaryReadyFlag |=> !auxiliaryResultWrite && !auxiliaryCoefWrite)
      else $error("auxiliary register written while ready set");
   a_start_clear: assert property (startOp && !primaryEvt.done && !auxiliaryEvt.done
                                   |=> !s.primaryErrorFlag && !s.calDoneFlag && !s.primaryReadyFlag)
      else $error("start write did not clear status");
   a_cal_hold: assert property (s.calDoneFlag && !startOp |=> s.calDoneFlag)
      else $error("calibration flag lost without start write");
   a_ref_active: assert property (s.extReferenceMissing |-> $past(referenceLow) && $past(anyActive))
      else $error("reference flag set while inactive");
   a_clamp_ones: assert property (primaryAccept && !calOp && s.extReferenceMissing && primaryExtRef
                                  |=> primaryResultWrite && (primaryResult == '1))
      else $error("primary result not clamped");
   a_mode_reset: assert property (modeWrite |=> converterReset ##1 !converterReset || $past(modeWrite))
      else $error("mode write did not pulse converter reset");
   a_single_return: assert property (primaryAccept && s.operationField == OP_SINGLE && !modeWrite
                                     |=> operationField == OP_POWER_DOWN)
      else $error("single conversion did not return to power-down");
   a_temp_cal: assert property (auxiliaryAccept && calOp && tempSensorSelected
                                |=> s.auxiliaryErrorFlag && !auxiliaryCoefWrite && s.auxiliaryReadyFlag)
      else $error("temperature sensor calibration not flagged");
   a_rsvd_zero: assert property (sfrReq.read && sfrReq.addr == DMSC_STAT_ADDR |=> sfrRdData[1:0] == 2'b00)
      else $error("reserved status bits not zero");

   // Ready flags: set by completion, cleared by software zeros
   a_aux_ready_set: assert property (auxiliaryEvt.done && !s.auxiliaryReadyFlag |=> s.auxiliaryReadyFlag)
      else $error("auxiliary ready not set after completion");
   a_sw_clear: assert property (statWrite && !sfrReq.wrData[STAT_PRI_RDY_BIT] && !primaryAccept
                                |=> !s.primaryReadyFlag)
      else $error("software zero did not clear primary ready");
   a_aux_sw_clear: assert property (statWrite && !sfrReq.wrData[STAT_AUX_RDY_BIT] && !auxiliaryAccept
                                    |=> !s.auxiliaryReadyFlag)
      else $error("software zero did not clear auxiliary ready");
   a_sw_ones_keep: assert property (statWrite && sfrReq.wrData[STAT_PRI_RDY_BIT] && s.primaryReadyFlag
                                    |=> s.primaryReadyFlag)
      else $error("software one cleared primary ready");

   // Error and calibration flags
   a_cal_set: assert property (primaryAccept && calOp |=> s.calDoneFlag)
      else $error("calibration flag not set on completion");
   a_sat_error: assert property (primaryAccept && !calOp && primaryEvt.saturated
                                 |=> s.primaryErrorFlag)
      else $error("primary saturation not flagged");
   a_cal_fault: assert property (primaryAccept && calOp && primaryEvt.calFault
                                 |=> s.primaryErrorFlag && !primaryCoefWrite)
      else $error("primary calibration fault not flagged");
   a_aux_sat: assert property (auxiliaryAccept && !calOp && auxiliaryEvt.saturated
                               |=> s.auxiliaryErrorFlag)
      else $error("auxiliary saturation not flagged");
   a_aux_fault: assert property (auxiliaryAccept && calOp && auxiliaryEvt.calFault
                                 |=> s.auxiliaryErrorFlag && !auxiliaryCoefWrite)
      else $error("auxiliary calibration fault not flagged");
   a_err_clear: assert property (startOp && !auxiliaryAccept
                                 |=> !s.auxiliaryErrorFlag && !s.auxiliaryReadyFlag)
      else $error("start write did not clear auxiliary status");
   a_idle_keep: assert property (modeWrite && writtenOp == OP_IDLE && s.primaryErrorFlag
                                 |=> s.primaryErrorFlag)
      else $error("idle write cleared primary error");
   a_cal_ready_clear: assert property (startOp && writtenOp >= OP_CAL_INT_ZS && !primaryAccept && !auxiliaryAccept
                                       |=> !s.primaryReadyFlag && !s.auxiliaryReadyFlag)
      else $error("calibration write did not clear ready flags");

   // Mode register, reference flag and load pulses
   a_enable_load: assert property (modeWrite
                                   |=> s.primaryEnable == $past(sfrReq.wrData[MODE_PRI_EN_BIT])
                                       && s.auxiliaryEnable == $past(sfrReq.wrData[MODE_AUX_EN_BIT]))
      else $error("enable bits not loaded by mode write");
   a_field_load: assert property (modeWrite |=> operationField == $past(writtenOp))
      else $error("operation field not loaded by mode write");
   a_cal_return: assert property (primaryAccept && calOp && !modeWrite
                                  |=> operationField == OP_POWER_DOWN)
      else $error("calibration did not return to power-down");
   a_ref_idle: assert property (!anyActive |=> !s.extReferenceMissing)
      else $error("reference flag set with no converter active");
   a_aux_clamp: assert property (auxiliaryAccept && !calOp && s.extReferenceMissing && auxiliaryExtRef
                                 |=> auxiliaryResultWrite && (auxiliaryResult == '1))
      else $error("auxiliary result not clamped");
   a_result_load: assert property (primaryAccept && !calOp && !(s.extReferenceMissing && primaryExtRef)
                                   |=> primaryResultWrite && (primaryResult == $past(primaryRaw)))
      else $error("primary result not loaded from filter");
   a_rsvd_mode: assert property (sfrReq.read && sfrReq.addr == DMSC_MODE_ADDR
                                 |=> sfrRdData[7:6] == 2'b00 && !sfrRdData[3])
      else $error("reserved mode bits not zero");

   c_single_done: cover property (startOp && writtenOp == OP_SINGLE ##[1:50] primaryResultWrite);
   c_cal_done: cover property (s.operationField == OP_CAL_INT_ZS ##[1:50] primaryCoefWrite);
   c_sw_clear: cover property (s.primaryReadyFlag ##1 statWrite ##1 !s.primaryReadyFlag);
   // Auxiliary calibration and a primary completion while the reference flag is set
   c_aux_cal: cover property (s.operationField == OP_CAL_INT_ZS ##[1:50] auxiliaryCoefWrite);
   c_ref_clamp: cover property (s.extReferenceMissing && primaryAccept);

endmodule // dmsc_ctrl

// [dmsc_ctrl_tb.sv]
// Self-checking testbench of the converter mode and status block
module dmsc_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import dmsc_pkg::*;

   logic          clock              = 1'b0;
   logic          rst_n              = 1'b0;
   dmsc_sfr_req_t sfrReq             = '0;
   dmsc_evt_t     primaryEvt         = '0;
   dmsc_evt_t     auxiliaryEvt       = '0;
   logic [23:0]   primaryRaw         = 24'h00_0000;
   logic [15:0]   auxiliaryRaw       = 16'h0000;
   logic          referenceLow       = 1'b0;
   logic          primaryExtRef      = 1'b0;
   logic          auxiliaryExtRef    = 1'b0;
   logic          tempSensorSelected = 1'b0;
   logic [7:0]    sfrRdData;
   dmsc_op_t      operationField;
   logic          primaryRun, auxiliaryRun, converterReset;
   logic          primaryResultWrite, primaryCoefWrite, auxiliaryResultWrite, auxiliaryCoefWrite;
   logic [23:0]   primaryResult;
   logic [15:0]   auxiliaryResult;
   int            failCount = 0;
   int            nCompared = 0;
   integer        seed      = 47;
   logic [7:0]    rd;
   logic [23:0]   raw;
   logic          sat, useAux, primary_error_flag, auxiliary_error_flag;

   dmsc_ctrl dut (.clock(clock), .rst_n(rst_n), .sfrReq(sfrReq), .sfrRdData(sfrRdData),
      .primaryEvt(primaryEvt), .primaryRaw(primaryRaw), .auxiliaryEvt(auxiliaryEvt),
      .auxiliaryRaw(auxiliaryRaw), .referenceLow(referenceLow), .primaryExtRef(primaryExtRef),
      .auxiliaryExtRef(auxiliaryExtRef), .tempSensorSelected(tempSensorSelected),
      .operationField(operationField), .primaryRun(primaryRun), .auxiliaryRun(auxiliaryRun),
      .converterReset(converterReset), .primaryResultWrite(primaryResultWrite),
      .primaryResult(primaryResult), .primaryCoefWrite(primaryCoefWrite),
      .auxiliaryResultWrite(auxiliaryResultWrite), .auxiliaryResult(auxiliaryResult),
      .auxiliaryCoefWrite(auxiliaryCoefWrite));

   // Free-running core clock, 10 ns period
   always #5 clock = ~clock;

   // Verdict and end of run, shared by the main sequence and the watchdog
   task automatic testDone();
      $display("Compared %0d, mismatches %0d", nCompared, failCount);
      if (failCount == 0 && nCompared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // Compare tasks for a byte, a single flag and a result of up to 24 bits
   task automatic chkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
      nCompared++;
      if (got !== exp) begin
         failCount++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic chkFlag(input logic got, input logic exp, input string what);
      chkByte({7'h00, got}, {7'h00, exp}, what);
   endtask
   task automatic chkData(input logic [23:0] got, input logic [23:0] exp, input string what);
      nCompared++;
      if (got !== exp) begin
         failCount++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Expected status byte built from the individual flags
   function automatic logic [7:0] expStat(logic r0, logic r1, logic e0, logic e1);
      return {r0, r1, 2'b00, e0, e1, 2'b00};
   endfunction

   // One register cycle: strobe for one edge, read data sampled the cycle after
   task automatic sfrCycle(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge clock);
      sfrReq = '{write: wr, read: !wr, addr: addr, wrData: data};
      @(negedge clock);
      sfrReq.write = 1'b0;
      sfrReq.read  = 1'b0;
      rd = sfrRdData;
   endtask

   // Mode write, then checks of the reset pulse, the field and the read-back
   task automatic wrMode(input logic [7:0] data);
      sfrCycle(1'b1, DMSC_MODE_ADDR, data);
      chkFlag(converterReset, 1'b1, "converter reset");
      chkByte({5'h00, operationField}, {5'h00, data[2:0]}, "field");
      sfrCycle(1'b0, DMSC_MODE_ADDR, 8'h00);
      chkByte(rd, data & 8'h37, "mode readback");
   endtask

   task automatic readStat(input logic [7:0] exp, input logic [7:0] mask);
      sfrCycle(1'b0, DMSC_STAT_ADDR, 8'h00);
      chkByte(rd & mask, exp & mask, "status");
   endtask

   // One completion pulse from either converter; outputs are settled on return
   task automatic evt(input logic aux, input logic s, input logic flt, input logic [23:0] r);
      @(negedge clock);
      primaryRaw   = r;
      auxiliaryRaw = r[15:0];
      if (aux) begin
         auxiliaryEvt = '{done: 1'b1, saturated: s, calFault: flt};
      end else begin
         primaryEvt = '{done: 1'b1, saturated: s, calFault: flt};
      end
      @(negedge clock);
      primaryEvt   = '0;
      auxiliaryEvt = '0;
   endtask

   // Watchdog: the sequence needs well under a thousand cycles
   initial begin
      #100_000;
      failCount++;
      $display("ERROR %0t: watchdog expired", $time);
      testDone();
   end

   initial begin
      repeat (2) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      // Reset values and an unmapped address
      readStat(DMSC_STAT_RESET, 8'hFF);
      chkByte({5'h00, operationField}, DMSC_MODE_RESET, "reset field");
      sfrCycle(1'b1, 8'hD2, 8'hFF);
      sfrCycle(1'b0, 8'hD2, 8'h00);
      chkByte(rd, DMSC_RD_IDLE, "unmapped read");
      sfrCycle(1'b0, DMSC_MODE_ADDR, 8'h00);
      chkByte(rd, DMSC_MODE_RESET, "mode after unmapped write");
      wrMode(8'hFF);
      $display("Test reset and map finished");
      // Single conversion, then gating while ready stays set
      wrMode(8'h22);
      chkFlag(primaryRun, 1'b1, "primary run");
      raw = 24'($random(seed));
      evt(1'b0, 1'b0, 1'b0, raw);
      chkFlag(primaryResultWrite, 1'b1, "result write");
      chkData(primaryResult, raw, "primary result");
      chkByte({5'h00, operationField}, 8'h00, "field back to zero");
      readStat(8'h80, 8'hFF);
      wrMode(8'h23);
      readStat(8'h00, 8'hFF);
      evt(1'b0, 1'b0, 1'b0, raw);
      evt(1'b0, 1'b0, 1'b0, ~raw);
      chkFlag(primaryResultWrite, 1'b0, "write while ready");
      sfrCycle(1'b1, DMSC_STAT_ADDR, 8'hFF);
      readStat(8'h80, 8'hFF);
      sfrCycle(1'b1, DMSC_STAT_ADDR, 8'h7F);
      readStat(8'h00, 8'hFF);
      evt(1'b0, 1'b0, 1'b0, raw);
      chkFlag(primaryResultWrite, 1'b1, "write after clear");
      $display("Test ready flag finished");
      // Saturation error, idle write keeps it, start write clears it
      wrMode(8'h22);
      evt(1'b0, 1'b1, 1'b0, 24'hFF_FFFF);
      readStat(8'h88, 8'hFF);
      wrMode(8'h01);
      chkFlag(primaryRun, 1'b0, "run in idle");
      readStat(8'h88, 8'hFF);
      wrMode(8'h22);
      readStat(8'h00, 8'hFF);
      wrMode(8'h20);
      chkFlag(primaryRun, 1'b0, "run in power-down");
      $display("Test error flag finished");
      // Every calibration code on the primary converter, a primary fault, auxiliary calibration with and without temperature sensor
      for (int op = 4; op < 8; op++) begin
         wrMode(8'h20 | op[7:0]);
         readStat(8'h00, 8'hFF);
         evt(1'b0, 1'b0, 1'b0, raw);
         chkFlag(primaryCoefWrite, 1'b1, "primary coef");
         chkByte({5'h00, operationField}, 8'h00, "cal field");
         readStat(8'hA0, 8'hFF);
      end
      wrMode(8'h24);
      evt(1'b0, 1'b0, 1'b1, raw);
      chkFlag(primaryCoefWrite, 1'b0, "faulty coef");
      readStat(8'h88, 8'hDF);
      wrMode(8'h14);
      evt(1'b1, 1'b0, 1'b0, raw);
      chkFlag(auxiliaryCoefWrite, 1'b1, "aux coef");
      readStat(8'h60, 8'hFF);
      sfrCycle(1'b1, DMSC_STAT_ADDR, 8'h00);
      readStat(8'h20, 8'hFF);
      tempSensorSelected = 1'b1;
      wrMode(8'h17);
      evt(1'b1, 1'b0, 1'b0, raw);
      chkFlag(auxiliaryCoefWrite, 1'b0, "temp sensor coef");
      readStat(8'h44, 8'hDF);
      tempSensorSelected = 1'b0;
      $display("Test calibration finished");
      // Missing reference flag and clamping
      wrMode(8'h03);
      referenceLow = 1'b1;
      readStat(8'h00, 8'hFF);
      wrMode(8'h13);
      chkFlag(auxiliaryRun, 1'b1, "aux run");
      readStat(8'h10, 8'hFF);
      wrMode(8'h33);
      primaryExtRef   = 1'b1;
      auxiliaryExtRef = 1'b1;
      readStat(8'h10, 8'hFF);
      evt(1'b0, 1'b0, 1'b0, 24'h12_3456);
      chkData(primaryResult, 24'hFF_FFFF, "clamped result");
      evt(1'b1, 1'b0, 1'b0, 24'h12_3456);
      chkData({8'h00, auxiliaryResult}, 24'h00_FFFF, "clamped aux result");
      referenceLow = 1'b0;
      readStat(8'hC0, 8'hF3);
      primaryExtRef   = 1'b0;
      auxiliaryExtRef = 1'b0;
      $display("Test reference finished");
      // Random traffic on both converters in continuous mode
      wrMode(8'h33);
      wrMode(8'h33);
      primary_error_flag = 1'b0;
      auxiliary_error_flag = 1'b0;
      repeat (12) begin
         useAux = 1'($random(seed));
         sat    = 1'($random(seed));
         raw    = 24'($random(seed));
         evt(useAux, sat, 1'b0, raw);
         if (useAux) begin
            chkFlag(auxiliaryResultWrite, 1'b1, "aux write");
            chkData({8'h00, auxiliaryResult}, {8'h00, raw[15:0]}, "aux result");
            auxiliary_error_flag = auxiliary_error_flag | sat;
         end else begin
            chkFlag(primaryResultWrite, 1'b1, "primary write");
            chkData(primaryResult, raw, "primary result");
            primary_error_flag = primary_error_flag | sat;
         end
         readStat(expStat(!useAux, useAux, primary_error_flag, auxiliary_error_flag), 8'hFF);
         sfrCycle(1'b1, DMSC_STAT_ADDR, 8'h00);
      end
      $display("Test random traffic finished");
      testDone();
   end

endmodule // dmsc_ctrl_tb
